/* hdl/sepr_core.sv */
// command decode, status register and write protection of a serial eeprom slave
//
// Function
// - write-protect pin low with arm set blocks changes to protect bits and arm.
// - while hold is low, clock, input and output activity are ignored.
// - hold tied high leaves transfers uninterrupted.
// - status is read-only when hardware protected or the write latch is clear.
// - status bit 0 shows busy, 1 meaning internal operation in progress.
// - while busy only the status read command is accepted.
// - bit 1 is the write latch; when clear nothing may be modified.
// - write latch clears to 0 at power-up.
// - protect bits sit at bits 2 and 3, retained, starting at 0.
// - bits 4 to 6 are not stored and read 0 outside write cycles.
// - bit 7 arms hardware protection, which never blocks array writes.
// - arm cannot be cleared while write-protect pin is already low.
// - during an internal write cycle status reads return all ones.
// - protect encoding covers none, top quarter, top half or whole array.
// - input sampled on rising clock, opcode first, most significant bit first.
// - output bits shift out on falling clock, most significant bit first.
// - rising chip select ends the frame and starts the operation.
// - latch set, latch clear and status read opcodes ignore bit 3.
// - status write takes one byte; array read and write take 16-bit address.
// - id read opcode and shared id write, lock read and lock opcode.
// - latch clear, status write and array write clear the latch on completion.
// - address bit 10 picks id write (0) or lock read and lock (1).
// - status write stores protect bits and arm only, when enabled and unprotected.
`timescale 1ns/1ps
module sepr_core import sepr_pkg::*; #(
    parameter int WRITE_CYC = SEPR_WRITE_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_cs_b,
    input wire logic i_sck,
    input wire logic i_si,
    input wire logic i_wp_b,
    input wire logic i_hold_b,
    output logic o_so,
    output logic o_so_oe,
    output logic o_wr_go,
    output logic [13:0] o_wr_addr,
    output logic [7:0] o_wr_data,
    output logic [7:0] o_status,
    output logic o_id_sel_lock
);
    // pin synchronisers
    logic [1:0] cs_s_r, sck_s_r, si_s_r, wp_s_r, hold_s_r;
    logic sck_d_r;
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cs_s_r <= 2'h3;
            sck_s_r <= 2'h0;
            si_s_r <= 2'h0;
            wp_s_r <= 2'h3;
            hold_s_r <= 2'h3;
            sck_d_r <= 1'b0;
        end else begin
            cs_s_r <= {cs_s_r[0], i_cs_b};
            sck_s_r <= {sck_s_r[0], i_sck};
            si_s_r <= {si_s_r[0], i_si};
            wp_s_r <= {wp_s_r[0], i_wp_b};
            hold_s_r <= {hold_s_r[0], i_hold_b};
            sck_d_r <= sck_s_r[1];
        end
    end

    wire cs_b = cs_s_r[1];
    wire wp_b = wp_s_r[1];
    wire held = !hold_s_r[1];
    wire sck_rise = sck_s_r[1] && !sck_d_r && !cs_b && !held;
    wire sck_fall = !sck_s_r[1] && sck_d_r && !cs_b && !held;
    logic cs_d_r;
    wire cs_rise = cs_b && !cs_d_r;

    // state
    sepr_state_t state_r, state_nxt;
    logic [31:0] wcnt_r;
    logic wel_r, bp_lo_r, bp_hi_r, arm_r;
    logic [5:0] bcnt_r;
    logic [7:0] opc_r;
    logic [15:0] addr_r;
    logic [7:0] dat_r;
    logic [7:0] sh_r;
    logic so_r, oe_r;
    logic busy_r, go_r;

    wire hw_prot = !wp_b && arm_r;
    wire [7:0] opm = opc_r & SEPR_OP_MASK;
    wire is_set_write_latch_cmd = (opm == SEPR_OP_SET_WRITE_LATCH_CMD);
    wire is_clear_write_latch_cmd = (opm == SEPR_OP_CLEAR_WRITE_LATCH_CMD);
    wire is_status_read_cmd = (opm == SEPR_OP_STATUS_READ_CMD);
    wire is_status_write_cmd = (opm == SEPR_OP_STATUS_WRITE_CMD);
    wire is_write = (opm == SEPR_OP_WRITE);
    wire is_idwr = (opm == SEPR_OP_IDWR);
    wire id_lock = addr_r[SEPR_IDSEL_BIT];
    wire [13:0] waddr = addr_r[13:0];
    // block protection range check
    wire in_prot = (bp_hi_r && bp_lo_r) ||
                   (bp_hi_r && (waddr >= SEPR_HALF_BASE)) ||
                   (bp_lo_r && (waddr >= SEPR_QTR_BASE));
    wire acc = !busy_r || is_status_read_cmd;
    wire status_write_cmd_ok = is_status_write_cmd && wel_r && !hw_prot && (bcnt_r == SEPR_STATUS_WRITE_CMD_DONE);
    wire write_ok = is_write && wel_r && !in_prot && (bcnt_r == SEPR_WDAT_DONE);
    wire idwr_ok = is_idwr && wel_r && (bcnt_r == SEPR_WDAT_DONE) && !(id_lock && bp_hi_r && bp_lo_r);
    wire start_wr = cs_rise && acc && (status_write_cmd_ok || write_ok || idwr_ok);
    wire arm_clr_bad = arm_r && !dat_r[SEPR_BIT_HWARM] && !wp_b;
    wire [7:0] st_live = {arm_r, 3'h0, bp_hi_r, bp_lo_r, wel_r, busy_r};
    wire [7:0] st_rd = busy_r ? SEPR_ALL_ONES : st_live;
    wire st_msb = st_rd[7]; // first bit out of a status read

    // self-timed write cycle
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SEPR_IDLE: begin
                if (start_wr) begin
                    state_nxt = SEPR_BUSY;
                end
            end
            SEPR_BUSY: begin
                if (wcnt_r == 32'(WRITE_CYC - 1)) begin
                    state_nxt = SEPR_IDLE;
                end
            end
            default: state_nxt = SEPR_IDLE;
        endcase
    end

    // busy counter and status bits; bits reset to factory value 0
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_r <= SEPR_IDLE;
            wcnt_r <= 32'h0;
            busy_r <= 1'b0;
            wel_r <= 1'b0;
            bp_lo_r <= 1'b0;
            bp_hi_r <= 1'b0;
            arm_r <= 1'b0;
            cs_d_r <= 1'b1;
            go_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cs_d_r <= cs_b;
            busy_r <= (state_nxt == SEPR_BUSY);
            wcnt_r <= (state_r == SEPR_BUSY) ? wcnt_r + 32'h1 : 32'h0;
            go_r <= cs_rise && acc && (write_ok || idwr_ok);
            if (cs_rise && acc && is_set_write_latch_cmd && (bcnt_r == SEPR_OPC_DONE)) begin
                wel_r <= 1'b1;
            end else if (cs_rise && acc && (is_clear_write_latch_cmd || status_write_cmd_ok || write_ok)) begin
                wel_r <= 1'b0;
            end
            if (status_write_cmd_ok && cs_rise && acc) begin
                bp_lo_r <= dat_r[SEPR_BIT_BP_LO];
                bp_hi_r <= dat_r[SEPR_BIT_BP_HI];
                if (!arm_clr_bad) begin
                    arm_r <= dat_r[SEPR_BIT_HWARM];
                end
            end
        end
    end

    // frame shifter: opcode, address and last data byte
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bcnt_r <= 6'h0;
            opc_r <= 8'h0;
            addr_r <= 16'h0;
            dat_r <= 8'h0;
        end else if (cs_b) begin
            bcnt_r <= 6'h0;
        end else if (sck_rise) begin
            if (bcnt_r != SEPR_CNT_MAX) begin
                bcnt_r <= bcnt_r + 6'h1;
            end
            if (bcnt_r < SEPR_OPC_DONE) begin
                opc_r <= {opc_r[6:0], si_s_r[1]};
            end else if (is_status_write_cmd) begin
                dat_r <= {dat_r[6:0], si_s_r[1]};
            end else if (bcnt_r < SEPR_ADR_DONE) begin
                addr_r <= {addr_r[14:0], si_s_r[1]};
            end else begin
                dat_r <= {dat_r[6:0], si_s_r[1]};
            end
        end
    end

    // status read output shifter, repeats every eight bits until the bit counter saturates at 63
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sh_r <= 8'h0;
            so_r <= 1'b0;
            oe_r <= 1'b0;
        end else if (cs_b) begin
            oe_r <= 1'b0;
        end else if (sck_fall && is_status_read_cmd && (bcnt_r >= SEPR_OPC_DONE)) begin
            if (bcnt_r[2:0] == 3'h0) begin
                so_r <= st_rd[7];
                sh_r <= {st_rd[6:0], 1'b0};
            end else begin
                so_r <= sh_r[7];
                sh_r <= {sh_r[6:0], 1'b0};
            end
            oe_r <= 1'b1;
        end else if (held) begin
            oe_r <= 1'b0;
        end
    end

    // registered outputs
    logic [7:0] stat_o_r;
    logic [13:0] wa_r;
    logic [7:0] wd_r;
    logic idl_r;
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            stat_o_r <= 8'h0;
            wa_r <= 14'h0;
            wd_r <= 8'h0;
            idl_r <= 1'b0;
        end else begin
            stat_o_r <= st_rd;
            wa_r <= waddr;
            wd_r <= dat_r;
            idl_r <= is_idwr && id_lock;
        end
    end
    assign o_so = so_r;
    assign o_so_oe = oe_r;
    assign o_wr_go = go_r;
    assign o_wr_addr = wa_r;
    assign o_wr_data = wd_r;
    assign o_status = stat_o_r;
    assign o_id_sel_lock = idl_r;

    // checks
    property p_wel_busy_read;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        busy_r |-> (st_rd == SEPR_ALL_ONES);
    endproperty
    a_wel_busy_read: assert property (p_wel_busy_read) else $error("status not all ones while busy");
    property p_prot_hold;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (!wp_b && arm_r && !busy_r) |=> (bp_lo_r == $past(bp_lo_r) && bp_hi_r == $past(bp_hi_r) && arm_r);
    endproperty
    a_prot_hold: assert property (p_prot_hold) else $error("protect bits changed under hw protection");
    property p_wel_clear_done;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        start_wr && !idwr_ok |=> !wel_r;
    endproperty
    a_wel_clear_done: assert property (p_wel_clear_done) else $error("write latch not cleared");
    property p_busy_start;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        start_wr |=> busy_r [*2];
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy not raised");
    property p_busy_only_status_read_cmd;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        busy_r |=> !go_r;
    endproperty
    a_busy_only_status_read_cmd: assert property (p_busy_only_status_read_cmd) else $error("write accepted while busy");
    property p_no_wel_no_write;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        !wel_r |=> !go_r;
    endproperty
    a_no_wel_no_write: assert property (p_no_wel_no_write) else $error("write without latch");
    property p_reserved_zero;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        !busy_r |-> (st_rd[6:4] == 3'h0 && st_rd[SEPR_BIT_BUSY] == 1'b0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");
    property p_so_quiet;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        cs_b |=> !oe_r;
    endproperty
    a_so_quiet: assert property (p_so_quiet) else $error("output driven while deselected");

    // checks on the hold input and the serial link
    property p_hold_freeze;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        held && !cs_b |=> $stable(bcnt_r) && $stable(opc_r);
    endproperty
    a_hold_freeze: assert property (p_hold_freeze) else $error("frame advanced while held");
    property p_hold_quiet;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        held |=> !oe_r;
    endproperty
    a_hold_quiet: assert property (p_hold_quiet) else $error("output driven while held");
    property p_so_first;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        sck_fall && is_status_read_cmd && (bcnt_r == SEPR_OPC_DONE) |=> (so_r == $past(st_msb));
    endproperty
    a_so_first: assert property (p_so_first) else $error("status msb not shifted first");

    // checks on the self-timed cycle
    property p_busy_stay;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        busy_r && (wcnt_r < 32'(WRITE_CYC - 1)) |=> busy_r;
    endproperty
    a_busy_stay: assert property (p_busy_stay) else $error("busy dropped early");
    property p_busy_end;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        busy_r && (wcnt_r == 32'(WRITE_CYC - 1)) |=> !busy_r;
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy held too long");

    // checks on protection and the write latch
    property p_array_free;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        cs_rise && !busy_r && is_write && wel_r && !in_prot && (bcnt_r == SEPR_WDAT_DONE) |=> go_r;
    endproperty
    a_array_free: assert property (p_array_free) else $error("allowed array write refused");
    property p_whole_locked;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        cs_rise && is_write && bp_hi_r && bp_lo_r |=> !go_r;
    endproperty
    a_whole_locked: assert property (p_whole_locked) else $error("write into fully protected array");
    property p_status_write_cmd_refused;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        cs_rise && is_status_write_cmd && (!wel_r || hw_prot) |=> $stable(bp_lo_r) && $stable(bp_hi_r) && $stable(arm_r);
    endproperty
    a_status_write_cmd_refused: assert property (p_status_write_cmd_refused) else $error("refused status write stored");
    property p_arm_kept;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        arm_r && !wp_b |=> arm_r;
    endproperty
    a_arm_kept: assert property (p_arm_kept) else $error("arm cleared with pin low");
    property p_wel_set;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        cs_rise && !busy_r && is_set_write_latch_cmd && (bcnt_r == SEPR_OPC_DONE) |=> wel_r;
    endproperty
    a_wel_set: assert property (p_wel_set) else $error("write latch not set");
    property p_wel_clear_clear_write_latch_cmd;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        cs_rise && !busy_r && is_clear_write_latch_cmd |=> !wel_r;
    endproperty
    a_wel_clear_clear_write_latch_cmd: assert property (p_wel_clear_clear_write_latch_cmd) else $error("latch clear ignored");
    property p_idsel;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        is_idwr |=> (idl_r == $past(id_lock));
    endproperty
    a_idsel: assert property (p_idsel) else $error("id select bit not reported");
endmodule

/* hdl/sepr_pkg.sv */
// constants for the serial eeprom command and protection block
package sepr_pkg;
    localparam int SEPR_CLK_HZ = 50_000_000;
    localparam int SEPR_WRITE_TIME_US = 5000;
    localparam int SEPR_WRITE_CYC = SEPR_WRITE_TIME_US * (SEPR_CLK_HZ / 1_000_000);
    localparam int SEPR_BIT_BUSY = 0;
    localparam int SEPR_BIT_WEL = 1;
    localparam int SEPR_BIT_BP_LO = 2;
    localparam int SEPR_BIT_BP_HI = 3;
    localparam int SEPR_BIT_HWARM = 7;
    localparam logic [7:0] SEPR_OP_MASK = 8'hF7;
    localparam logic [7:0] SEPR_OP_SET_WRITE_LATCH_CMD = 8'h06;
    localparam logic [7:0] SEPR_OP_CLEAR_WRITE_LATCH_CMD = 8'h04;
    localparam logic [7:0] SEPR_OP_STATUS_READ_CMD = 8'h05;
    localparam logic [7:0] SEPR_OP_STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] SEPR_OP_READ = 8'h03;
    localparam logic [7:0] SEPR_OP_WRITE = 8'h02;
    localparam logic [7:0] SEPR_OP_IDRD = 8'h83;
    localparam logic [7:0] SEPR_OP_IDWR = 8'h82;
    localparam int SEPR_IDSEL_BIT = 10;
    localparam logic [13:0] SEPR_QTR_BASE = 14'h3000;
    localparam logic [13:0] SEPR_HALF_BASE = 14'h2000;
    localparam logic [7:0] SEPR_ALL_ONES = 8'hFF;
    localparam logic [5:0] SEPR_OPC_DONE = 6'h08;
    localparam logic [5:0] SEPR_ADR_DONE = 6'h18;
    localparam logic [5:0] SEPR_STATUS_WRITE_CMD_DONE = 6'h10;
    localparam logic [5:0] SEPR_WDAT_DONE = 6'h20;
    localparam logic [5:0] SEPR_CNT_MAX = 6'h3F;
    typedef enum logic [1:0] {SEPR_IDLE, SEPR_BUSY} sepr_state_t;
endpackage

/* sim/sepr_master.sv */
// spi bus master model driving the eeprom command block
`timescale 1ns/1ps
module sepr_master (
    input wire logic i_clk_sys,
    input wire logic i_so,
    output logic o_cs_b,
    output logic o_sck,
    output logic o_si,
    output logic o_hold_b
);
    logic [31:0] rx;
    // idle bus: deselected, clock parked low, hold released
    initial begin
        o_cs_b = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
        o_hold_b = 1'b1;
        rx = '0;
    end
    // wait n system clocks, then step just past the edge
    task automatic tk(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask
    // one frame of n bits, msb first, with a hold pause before bit hp
    task automatic xfer(input int n, input logic [31:0] d, input int hp);
        o_cs_b = 1'b0;
        tk(4);
        for (int i = n - 1; i >= 0; i--) begin
            if (i == hp) begin
                o_hold_b = 1'b0;
                o_si = ~d[i];
                tk(2);
                o_sck = 1'b1;
                tk(4);
                o_sck = 1'b0;
                tk(2);
                o_hold_b = 1'b1;
            end
            o_si = d[i];
            tk(4);
            rx = {rx[30:0], i_so};
            o_sck = 1'b1;
            tk(4);
            o_sck = 1'b0;
        end
        tk(2);
        o_cs_b = 1'b1;
        o_si = ~o_si;
        tk(6);
    endtask
endmodule

/* sim/test_sepr_core.sv */
// self-checking bench for the eeprom command and protection block
`timescale 1ns/1ps
module test_sepr_core import sepr_pkg::*; ();
    localparam int WC = 400;
    logic clk, rst_b, cs_b, sck, si, wp_b, hold_b, so, so_oe, wr_go, id_lock;
    logic [13:0] wr_addr;
    logic [7:0] wr_data, status;
    int fail_count = 0;
    int n_compared = 0;
    int go_count = 0;
    // a released output shows the inverse, so a late enable is caught
    wire so_line = so_oe ? so : ~so;
    sepr_core #(.WRITE_CYC(WC)) u_sepr_core (.i_clk_sys(clk), .i_rst_b(rst_b), .i_cs_b(cs_b), .i_sck(sck),
        .i_si(si), .i_wp_b(wp_b), .i_hold_b(hold_b), .o_so(so), .o_so_oe(so_oe), .o_wr_go(wr_go),
        .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_status(status), .o_id_sel_lock(id_lock));
    sepr_master u_sepr_master (.i_clk_sys(clk), .i_so(so_line), .o_cs_b(cs_b), .o_sck(sck), .o_si(si),
        .o_hold_b(hold_b));
    // 50 mhz system clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // count accepted write pulses
    always @(posedge clk) begin
        if (wr_go === 1'b1) go_count++;
    end
    // compare and report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // verdict and end of run
    task automatic test_done;
        if (fail_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // plain frame without hold pause
    task automatic cmd(input int n, input logic [31:0] d);
        u_sepr_master.xfer(n, d, -1);
    endtask
    // status read over the wire and at the status port
    task automatic rd(input logic [7:0] exp);
        u_sepr_master.xfer(16, {16'h0, SEPR_OP_STATUS_READ_CMD, 8'h00}, -1);
        check(u_sepr_master.rx[7:0], exp);
        check(status, exp);
    endtask
    // wait for the write cycle to end, bounded
    task automatic idle;
        for (int k = 0; k < WC + 40 && status[0] !== 1'b0; k++) u_sepr_master.tk(1);
        check(status[0], 1'b0);
    endtask
    // latch set and clear, refused status write, shared id opcode
    task automatic t_basic;
        rd(8'h00);
        u_sepr_master.xfer(8, {24'h0, SEPR_OP_SET_WRITE_LATCH_CMD}, 3);
        rd(8'h02);
        cmd(8, {24'h0, SEPR_OP_CLEAR_WRITE_LATCH_CMD});
        rd(8'h00);
        cmd(16, {16'h0, SEPR_OP_STATUS_WRITE_CMD, 8'h8C});
        rd(8'h00);
        cmd(32, {SEPR_OP_IDWR, 16'h0400, 8'h02});
        check(id_lock, 1'b1);
        cmd(32, {SEPR_OP_IDWR, 16'h0000, 8'h02});
        check(id_lock, 1'b0);
    endtask
    // status write, busy period, commands refused while busy
    task automatic t_busy;
        cmd(8, {24'h0, SEPR_OP_SET_WRITE_LATCH_CMD});
        cmd(16, {16'h0, SEPR_OP_STATUS_WRITE_CMD, 8'hF4});
        check(status, SEPR_ALL_ONES);
        cmd(8, {24'h0, SEPR_OP_SET_WRITE_LATCH_CMD});
        rd(SEPR_ALL_ONES);
        idle;
        rd(8'h84);
    endtask
    // hardware protection blocks status but not the array
    task automatic t_hw;
        int n;
        wp_b = 1'b0;
        cmd(8, {24'h0, SEPR_OP_SET_WRITE_LATCH_CMD});
        cmd(16, {16'h0, SEPR_OP_STATUS_WRITE_CMD, 8'h00});
        idle;
        check(status & 8'hFD, 8'h84);
        cmd(8, {24'h0, SEPR_OP_SET_WRITE_LATCH_CMD});
        n = go_count;
        cmd(32, {SEPR_OP_WRITE, 16'h2FFF, 8'hA5});
        check(go_count - n, 1);
        check({wr_addr, wr_data}, {14'h2FFF, 8'hA5});
        idle;
        rd(8'h84);
        cmd(32, {SEPR_OP_WRITE, 16'h0100, 8'hA5});
        check(go_count - n, 1);
        wp_b = 1'b1;
    endtask
    // block protect setting against one array address
    task automatic t_prot(input logic [7:0] sr, input logic [13:0] a, input int ok);
        int n;
        cmd(8, {24'h0, SEPR_OP_SET_WRITE_LATCH_CMD});
        cmd(16, {16'h0, SEPR_OP_STATUS_WRITE_CMD, sr});
        idle;
        cmd(8, {24'h0, SEPR_OP_SET_WRITE_LATCH_CMD});
        n = go_count;
        cmd(32, {SEPR_OP_WRITE, 2'b00, a, 8'h5A});
        check(go_count - n, ok);
        idle;
    endtask
    // a reset in mid-run clears the write latch again
    task automatic t_reset;
        cmd(8, {24'h0, SEPR_OP_SET_WRITE_LATCH_CMD});
        rd(8'h02);
        rst_b = 1'b0;
        u_sepr_master.tk(2);
        check(status, 8'h00);
        rst_b = 1'b1;
        u_sepr_master.tk(4);
        rd(8'h00);
    endtask
    // reset, then the scenarios
    initial begin
        rst_b = 1'b0;
        wp_b = 1'b1;
        repeat (12) @(posedge clk);
        #1 rst_b = 1'b1;
        u_sepr_master.tk(4);
        t_basic;
        t_busy;
        t_hw;
        t_prot(8'h04, 14'h3000, 0);
        t_prot(8'h04, 14'h2FFF, 1);
        t_prot(8'h08, 14'h2000, 0);
        t_prot(8'h08, 14'h1FFF, 1);
        t_prot(8'h0C, 14'h0000, 0);
        t_prot(8'h00, 14'h3FFF, 1);
        t_reset;
        test_done;
    end
    // watchdog against a hang
    initial begin
        #1_000_000;
        fail_count++;
        test_done;
    end
endmodule
